// file: src/bsf_alu.v
// Purpose: four-bit adder of the slice
// Assumes: pure combinational, same clock domain as the caller
// Notes: overflow formed from the two top carries
`timescale 1ns/100ps
`include "bsf_defines.vh"
module bsf_alu (
    input  wire [3:0] r_i,
    input  wire [3:0] s_i,
    input  wire       c_i,
    output wire [3:0] f_o,
    output wire       co_o,
    output wire       ovr_o
);
    wire [2:0] low_sum;
    wire [1:0] top_sum;

    assign low_sum = {1'b0, r_i[1:0]} + {1'b0, s_i[1:0]} + {2'h0, c_i};
    assign top_sum = {1'b0, r_i[2]} + {1'b0, s_i[2]} + {1'b0, low_sum[2]};
    assign f_o     = r_i + s_i + {3'h0, c_i};
    assign co_o    = (r_i[3] & s_i[3]) | ((r_i[3] | s_i[3]) & top_sum[1]);
    assign ovr_o   = co_o ^ top_sum[1];
endmodule // bsf_alu

// file: src/bsf_defines.vh
// Purpose: constants for the four-bit special-function slice
// Assumes: included by bare name from the slice sources
// Notes: special codes sit on the upper instruction field while the low field is zero
`ifndef BSF_DEFINES_VH
`define BSF_DEFINES_VH
`define BSF_W            4
`define BSF_LOW_SPECIAL  5'h00
`define BSF_FN_UMUL      4'h0
`define BSF_FN_TCMUL     4'h2
`define BSF_FN_INC       4'h4
`define BSF_FN_SMCONV    4'h5
`define BSF_FN_TCLAST    4'h6
`define BSF_FN_DNORM     4'h8
`define BSF_FN_DIVFIRST  4'ha
`define BSF_FN_TCDIV     4'hc
`define BSF_FN_TCDIVC    4'he
`define BSF_FN_SNORM     4'hf
`define BSF_REGS         16
`define BSF_ZERO4        4'h0
`define BSF_MSB          3
`endif

// file: src/bsf_slice.v
// Purpose: special-function datapath of one cascadable four-bit alu slice
// Assumes: controls come from a pipeline register on clk_i; neighbour lines are synchronous
// Notes: two-way lines split into in, out and enable; zero line is open drain
// Operation
// RULE_01: low field zero selects special functions
// RULE_02: single normalize shifts queue up, zero in
// RULE_03: top carry out flags queue bits 3,2 differ
// RULE_04: top overflow flags queue bits 2,1 differ
// RULE_05: zero line high when queue all zero
// RULE_06: sign output shows top queue bit
// RULE_07: single normalize stores b plus carry
// RULE_08: double normalize shifts b and queue together
// RULE_09: double normalize flags from alu output
// RULE_10: double zero needs alu and queue zero
// RULE_11: conversion sign drives zero line
// RULE_12: most negative conversion raises overflow
// RULE_13: minus zero converts to all zero
// RULE_14: increment by one or two by carry
// RULE_15: lowest slice drives multiplier bit on zero
// RULE_16: multiply adds multiplicand when zero high
// RULE_17: multiply shifts result down into b
// RULE_18: top slice shifts carry into top
// RULE_19: queue and result shift down between slices
// RULE_20: controller preloads operands, steps sixteen times
// RULE_21: product ends in b and queue
// RULE_22: instruction enable high blocks writes
// RULE_23: each function has fixed upper code
`timescale 1ns/100ps
`include "bsf_defines.vh"
module bsf_slice (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire [4:0] low_instruction_field_i,
    input  wire [3:0] upper_instruction_field_i,
    input  wire [3:0] a_addr_i,
    input  wire [3:0] b_addr_i,
    input  wire [3:0] external_data_port_i,
    input  wire       src_ext_i,
    input  wire       carry_input_i,
    input  wire       instruction_enable_i,
    input  wire       top_slice_i,
    input  wire       lowest_slice_i,
    input  wire       zero_line_i,
    input  wire       queue_shift_low_port_i,
    input  wire       queue_shift_high_port_i,
    input  wire       result_shift_low_port_i,
    input  wire       result_shift_high_port_i,
    output reg        zero_line_o,
    output reg        zero_line_oe_o,
    output reg        queue_shift_low_port_o,
    output reg        queue_shift_low_port_oe_o,
    output reg        queue_shift_high_port_o,
    output reg        queue_shift_high_port_oe_o,
    output reg        result_shift_low_port_o,
    output reg        result_shift_low_port_oe_o,
    output reg        result_shift_high_port_o,
    output reg        result_shift_high_port_oe_o,
    output reg        carry_output_o,
    output reg        overflow_flag_o,
    output reg        sign_o,
    output reg  [3:0] y_o
);
    reg  [3:0] regs_ff [0:`BSF_REGS-1];
    reg  [3:0] queue_ff;
    reg        special;
    reg        is_snorm;
    reg        is_dnorm;
    reg        is_umul;
    reg        is_inc;
    reg        is_conv;
    reg  [3:0] op_r;
    reg  [3:0] op_s;
    reg        op_c;
    reg  [3:0] nxt_b;
    reg  [3:0] nxt_queue;
    reg        wr_b;
    reg        wr_q;
    reg        nxt_zero;
    reg        nxt_zero_oe;
    reg        nxt_co;
    reg        nxt_ovr;
    reg        nxt_sign;
    reg        nxt_ql;
    reg        nxt_ql_oe;
    reg        nxt_qh;
    reg        nxt_qh_oe;
    reg        nxt_rl;
    reg        nxt_rl_oe;
    reg        nxt_rh;
    reg        nxt_rh_oe;
    wire [3:0] ram_a;
    wire [3:0] ram_b;
    wire [3:0] src_s;
    wire [3:0] alu_f;
    wire       alu_co;
    wire       alu_ovr;
    wire       neg_s;
    integer    i;

    assign ram_a = regs_ff[a_addr_i];
    assign ram_b = regs_ff[b_addr_i];
    assign src_s = src_ext_i ? external_data_port_i : ram_b;
    // the top slice uses its own sign bit; the others see it on the zero line,
    // which is registered, so a chain must hold the conversion for two cycles
    assign neg_s = top_slice_i ? src_s[`BSF_MSB] : zero_line_i; // RULE_11

    bsf_alu u_alu (
        .r_i   (op_r),
        .s_i   (op_s),
        .c_i   (op_c),
        .f_o   (alu_f),
        .co_o  (alu_co),
        .ovr_o (alu_ovr)
    );

    always @* begin
        special  = (low_instruction_field_i == `BSF_LOW_SPECIAL); // RULE_01
        is_snorm = special && (upper_instruction_field_i == `BSF_FN_SNORM); // RULE_23
        is_dnorm = special && (upper_instruction_field_i == `BSF_FN_DNORM); // RULE_23
        is_umul  = special && (upper_instruction_field_i == `BSF_FN_UMUL); // RULE_23
        is_inc   = special && (upper_instruction_field_i == `BSF_FN_INC); // RULE_23
        is_conv  = special && (upper_instruction_field_i == `BSF_FN_SMCONV); // RULE_23
        op_r        = `BSF_ZERO4;
        op_s        = ram_b;
        op_c        = carry_input_i;
        nxt_b       = ram_b;
        nxt_queue   = queue_ff;
        wr_b        = 1'b0;
        wr_q        = 1'b0;
        nxt_zero    = 1'b0;
        nxt_zero_oe = 1'b0;
        nxt_co      = alu_co;
        nxt_ovr     = alu_ovr;
        nxt_sign    = alu_f[`BSF_MSB];
        nxt_ql      = 1'b0;
        nxt_ql_oe   = 1'b0;
        nxt_qh      = 1'b0;
        nxt_qh_oe   = 1'b0;
        nxt_rl      = 1'b0;
        nxt_rl_oe   = 1'b0;
        nxt_rh      = 1'b0;
        nxt_rh_oe   = 1'b0;
        if (is_snorm) begin
            op_s      = ram_b; // RULE_07
            nxt_b     = alu_f; // RULE_07
            wr_b      = 1'b1;
            // lowest slice feeds zero, others take the neighbour's bit
            nxt_queue = {queue_ff[2:0], lowest_slice_i ? 1'b0 : queue_shift_low_port_i}; // RULE_02
            wr_q      = 1'b1;
            nxt_qh    = queue_ff[`BSF_MSB];
            nxt_qh_oe = 1'b1;
            nxt_co    = queue_ff[3] ^ queue_ff[2]; // RULE_03
            nxt_ovr   = queue_ff[2] ^ queue_ff[1]; // RULE_04
            nxt_sign  = queue_ff[`BSF_MSB]; // RULE_06
            // open drain: release to let the line go high only when all zero
            nxt_zero    = 1'b0; // RULE_05
            nxt_zero_oe = (queue_ff != `BSF_ZERO4); // RULE_05
        end else if (is_dnorm) begin
            op_s      = ram_b;
            op_c      = 1'b0;
            nxt_b     = {alu_f[2:0], queue_shift_high_port_i}; // RULE_08
            wr_b      = 1'b1;
            nxt_queue = {queue_ff[2:0], lowest_slice_i ? 1'b0 : queue_shift_low_port_i}; // RULE_08
            wr_q      = 1'b1;
            nxt_qh    = queue_ff[`BSF_MSB];
            nxt_qh_oe = 1'b1;
            nxt_rh    = alu_f[`BSF_MSB];
            nxt_rh_oe = 1'b1;
            nxt_co    = alu_f[3] ^ alu_f[2]; // RULE_09
            nxt_ovr   = alu_f[2] ^ alu_f[1]; // RULE_09
            nxt_sign  = alu_f[`BSF_MSB]; // RULE_09
            nxt_zero    = 1'b0;
            nxt_zero_oe = (alu_f != `BSF_ZERO4) || (queue_ff != `BSF_ZERO4); // RULE_10
        end else if (is_conv) begin
            // negative per neg_s: invert and add carry_input_i
            op_s     = neg_s ? ~src_s : src_s; // RULE_11
            if (top_slice_i) begin
                op_s[`BSF_MSB] = src_s[`BSF_MSB]; // RULE_13
            end
            op_c     = carry_input_i;
            nxt_b    = alu_f;
            wr_b     = 1'b1;
            // minus zero plus carry wraps to all zero; on the top slice a negative input whose sum has zero low three bits is stored as zero
            if (top_slice_i && neg_s && (alu_f[2:0] == 3'h0)) begin
                nxt_b = `BSF_ZERO4; // RULE_13
            end
            nxt_ovr  = top_slice_i && neg_s && (src_s[2:0] == 3'h0)
                       ? (alu_f[2:0] == 3'h0) : alu_ovr; // RULE_12
            if (top_slice_i) begin
                nxt_zero    = 1'b0;
                nxt_zero_oe = !src_s[`BSF_MSB]; // RULE_11
            end
        end else if (is_inc) begin
            op_s  = src_s;
            op_r  = {3'h0, lowest_slice_i}; // RULE_14
            op_c  = carry_input_i; // RULE_14
            nxt_b = alu_f;
            wr_b  = 1'b1;
        end else if (is_umul) begin
            // lowest slice reads its own multiplier bit; the registered zero line lags
            op_r  = (lowest_slice_i ? queue_ff[0] : zero_line_i) ? ram_a : `BSF_ZERO4; // RULE_16
            op_s  = ram_b;
            op_c  = carry_input_i;
            nxt_b = {top_slice_i ? alu_co : result_shift_high_port_i, alu_f[3:1]}; // RULE_17 RULE_18
            wr_b  = 1'b1;
            nxt_queue = {queue_shift_high_port_i, queue_ff[3:1]}; // RULE_19
            wr_q      = 1'b1;
            nxt_ql    = queue_ff[0]; // RULE_19
            nxt_ql_oe = 1'b1;
            nxt_rl    = alu_f[0]; // RULE_19 RULE_21
            nxt_rl_oe = 1'b1;
            if (lowest_slice_i) begin
                nxt_zero    = 1'b0;
                nxt_zero_oe = !queue_ff[0]; // RULE_15
            end
        end
    end

    // register file and queue writes; no reset on the array keeps it a plain memory
    always @(posedge clk_i) begin
        if (!instruction_enable_i && wr_b) begin
            regs_ff[b_addr_i] <= nxt_b; // RULE_22
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            queue_ff <= `BSF_ZERO4;
        end else if (!instruction_enable_i && wr_q) begin
            queue_ff <= nxt_queue; // RULE_22
        end
    end

    // registered outputs: flags appear one cycle after the inputs that form them
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            zero_line_o                 <= 1'b0;
            zero_line_oe_o              <= 1'b0;
            queue_shift_low_port_o      <= 1'b0;
            queue_shift_low_port_oe_o   <= 1'b0;
            queue_shift_high_port_o     <= 1'b0;
            queue_shift_high_port_oe_o  <= 1'b0;
            result_shift_low_port_o     <= 1'b0;
            result_shift_low_port_oe_o  <= 1'b0;
            result_shift_high_port_o    <= 1'b0;
            result_shift_high_port_oe_o <= 1'b0;
            carry_output_o              <= 1'b0;
            overflow_flag_o             <= 1'b0;
            sign_o                      <= 1'b0;
            y_o                         <= `BSF_ZERO4;
        end else begin
            zero_line_o                 <= nxt_zero;
            zero_line_oe_o              <= nxt_zero_oe;
            queue_shift_low_port_o      <= nxt_ql;
            queue_shift_low_port_oe_o   <= nxt_ql_oe;
            queue_shift_high_port_o     <= nxt_qh;
            queue_shift_high_port_oe_o  <= nxt_qh_oe;
            result_shift_low_port_o     <= nxt_rl;
            result_shift_low_port_oe_o  <= nxt_rl_oe;
            result_shift_high_port_o    <= nxt_rh;
            result_shift_high_port_oe_o <= nxt_rh_oe;
            carry_output_o              <= nxt_co;
            overflow_flag_o             <= nxt_ovr;
            sign_o                      <= nxt_sign;
            y_o                         <= nxt_b;
        end
    end
endmodule // bsf_slice

// file: verif/bsf_far_side.sv
// Purpose: neighbour lines and shift muxes around a lone slice
// Assumes: the slice is strapped as both top and lowest
// Notes: unused neighbour inputs toggle so a stale level never passes
`timescale 1ns/100ps
module bsf_far_side (
    input  wire clk_i,
    input  wire zero_oe_i,
    input  wire res_low_i,
    input  wire fill_en_i,
    input  wire fill_bit_i,
    output wire zero_line_o,
    output wire q_high_o,
    output wire q_low_o,
    output wire r_high_o,
    output wire r_low_o
);
    reg toggle_ff = 1'b0;
    always @(posedge clk_i) toggle_ff <= ~toggle_ff;
    assign zero_line_o = ~zero_oe_i;
    // fill mux lets the controller preload the queue from the top
    assign q_high_o = fill_en_i ? fill_bit_i : res_low_i;
    assign q_low_o = toggle_ff;
    assign r_high_o = ~toggle_ff;
    assign r_low_o = toggle_ff;
endmodule // bsf_far_side

// file: verif/bsf_slice_monitor.sv
// Purpose: concurrent checks on the special-function slice ports
// Assumes: flags and results are registered one edge after their cause
// Notes: only a lone slice strapped as top and lowest is judged here
`timescale 1ns/100ps
`include "bsf_defines.vh"
module bsf_slice_monitor (
    input wire       clk_i,
    input wire       rstn_i,
    input wire [4:0] low_instruction_field_i,
    input wire [3:0] upper_instruction_field_i,
    input wire [3:0] b_addr_i,
    input wire [3:0] external_data_port_i,
    input wire       src_ext_i,
    input wire       carry_input_i,
    input wire       instruction_enable_i,
    input wire       top_slice_i,
    input wire       lowest_slice_i,
    input wire       zero_line_oe_o,
    input wire       carry_output_o,
    input wire       overflow_flag_o,
    input wire       sign_o,
    input wire [3:0] y_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire sp = low_instruction_field_i == `BSF_LOW_SPECIAL && !instruction_enable_i
              && top_slice_i && lowest_slice_i;
    wire sn = sp && upper_instruction_field_i == `BSF_FN_SNORM;
    wire ix = sp && upper_instruction_field_i == `BSF_FN_INC && src_ext_i;
    wire cx = sp && upper_instruction_field_i == `BSF_FN_SMCONV && src_ext_i;
    // two shifts in a row let one flag be predicted from the previous set
    sequence two_norm;
        sn ##1 (sn && $stable(b_addr_i));
    endsequence
    chk_early_norm_flag: assert property (two_norm |=> carry_output_o == $past(overflow_flag_o))
        else $error("carry out does not follow the early flag");
    chk_norm_sign_pair: assert property (two_norm |=> $past(carry_output_o) == ($past(sign_o) ^ sign_o))
        else $error("normalize flag disagrees with sign bits");
    chk_shift_count: assert property (two_norm |=> y_o == $past(y_o) + $past(carry_input_i))
        else $error("normalize count wrong");
    chk_zero_flags: assert property (sn ##1 !zero_line_oe_o |-> !sign_o && !carry_output_o && !overflow_flag_o)
        else $error("zero queue with flags set");
    chk_inc_value: assert property (ix |=> y_o == $past(external_data_port_i) + 4'h1 + $past(carry_input_i))
        else $error("increment result wrong");
    chk_conv_sign: assert property (cx |=> zero_line_oe_o == !$past(external_data_port_i[3]))
        else $error("conversion sign not on zero line");
    chk_conv_ovr: assert property (cx && external_data_port_i == 4'h8 |=> overflow_flag_o)
        else $error("most negative conversion without overflow");
    chk_minus_zero: assert property (cx && external_data_port_i == 4'h8 |=> y_o == 4'h0)
        else $error("minus zero not converted to zero");
endmodule // bsf_slice_monitor
bind bsf_slice bsf_slice_monitor u_mon (.clk_i, .rstn_i, .low_instruction_field_i,
    .upper_instruction_field_i, .b_addr_i, .external_data_port_i, .src_ext_i, .carry_input_i,
    .instruction_enable_i, .top_slice_i, .lowest_slice_i, .zero_line_oe_o, .carry_output_o,
    .overflow_flag_o, .sign_o, .y_o);

// file: verif/bsf_slice_tb_top.sv
// Purpose: directed checks of the special-function slice
// Assumes: one slice strapped as top and lowest, so words are four bits
// Notes: results are read just after the edge that registers them
`timescale 1ns/100ps
`include "bsf_defines.vh"
module bsf_slice_tb_top;
    reg        clk_i = 1'b0;
    reg        rstn_i = 1'b0;
    reg  [4:0] low_f = 5'h00, lo_n = 5'h00;
    reg  [3:0] up_f = 4'h0, a_ad = 4'h1, b_ad = 4'h0, ext = 4'h0, q, p;
    reg        src = 1'b0, cin = 1'b0, instruction_enable = 1'b0, ien_n = 1'b0, fill_en = 1'b0, fill_bit = 1'b0;
    reg  [4:0] s;
    wire       z_oe, co, overflow_flag, sgn, r_lo, zl, qh, ql, rh, rl;
    wire [3:0] y;
    integer    errors = 0, checks_done = 0, cyc = 0, i;
    bsf_slice u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .low_instruction_field_i(low_f),
        .upper_instruction_field_i(up_f), .a_addr_i(a_ad), .b_addr_i(b_ad),
        .external_data_port_i(ext), .src_ext_i(src), .carry_input_i(cin),
        .instruction_enable_i(instruction_enable), .top_slice_i(1'b1), .lowest_slice_i(1'b1),
        .zero_line_i(zl), .queue_shift_low_port_i(ql), .queue_shift_high_port_i(qh),
        .result_shift_low_port_i(rl), .result_shift_high_port_i(rh), .zero_line_o(),
        .zero_line_oe_o(z_oe), .queue_shift_low_port_o(), .queue_shift_low_port_oe_o(),
        .queue_shift_high_port_o(), .queue_shift_high_port_oe_o(),
        .result_shift_low_port_o(r_lo), .result_shift_low_port_oe_o(),
        .result_shift_high_port_o(), .result_shift_high_port_oe_o(),
        .carry_output_o(co), .overflow_flag_o(overflow_flag), .sign_o(sgn), .y_o(y));
    bsf_far_side u_far (.clk_i(clk_i), .zero_oe_i(z_oe), .res_low_i(r_lo), .fill_en_i(fill_en),
        .fill_bit_i(fill_bit), .zero_line_o(zl), .q_high_o(qh), .q_low_o(ql), .r_high_o(rh),
        .r_low_o(rl));
    initial forever #2 clk_i = ~clk_i;
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // umul with sx high feeds the queue from the fill mux instead of the loop
    task step(input [3:0] fn, input [3:0] b, input [3:0] d, input c, input sx);
        begin
            @(negedge clk_i);
            low_f = lo_n;
            instruction_enable = ien_n;
            up_f = fn;
            b_ad = b;
            ext = d;
            cin = c;
            src = sx;
            fill_en = (fn == `BSF_FN_UMUL) && sx;
            fill_bit = d[0];
            @(posedge clk_i);
            #1;
        end
    endtask
    task load_q(input [3:0] v);
        integer k;
        for (k = 0; k < 4; k = k + 1) begin
            step(`BSF_FN_UMUL, 4'h0, {3'h0, v[k]}, 1'b0, 1'b1);
            check(y, 4'h0);
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", errors, checks_done);
            if (errors == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 500) begin
            errors = errors + 1;
            finish_test;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        step(`BSF_FN_INC, 4'h0, 4'hf, 1'b0, 1'b1);
        check(y, 4'h0);
        step(`BSF_FN_INC, 4'h1, 4'ha, 1'b0, 1'b1);
        check(y, 4'hb);
        for (i = 0; i < 4; i = i + 1) begin
            step(`BSF_FN_INC, 4'h2, 4'(i * 5), i[0], 1'b1);
            check(y, 4'(i * 5 + 1 + i[0]));
        end
        // enable high, non-special low field and a reserved code must all leave R0 alone
        ien_n = 1'b1;
        step(`BSF_FN_INC, 4'h0, 4'h5, 1'b0, 1'b1);
        ien_n = 1'b0;
        lo_n = 5'h01;
        step(`BSF_FN_INC, 4'h0, 4'h5, 1'b0, 1'b1);
        lo_n = 5'h00;
        step(4'h1, 4'h0, 4'h5, 1'b0, 1'b1);
        step(`BSF_FN_INC, 4'h0, 4'h0, 1'b0, 1'b0);
        check(y, 4'h1);
        step(`BSF_FN_INC, 4'h0, 4'hf, 1'b0, 1'b1);
        step(`BSF_FN_SNORM, 4'h2, 4'h0, 1'b1, 1'b0);
        check({z_oe, co, overflow_flag, sgn}, 4'h0);
        check(y, 4'h2);
        step(`BSF_FN_SMCONV, 4'h3, 4'h8, 1'b1, 1'b1);
        check({overflow_flag, z_oe}, 4'h2);
        check(y, 4'h0);
        step(`BSF_FN_SMCONV, 4'h3, 4'h3, 1'b0, 1'b1);
        check({z_oe, y}, 5'h13);
        load_q(4'h3);
        q = 4'h3;
        for (i = 0; i < 4; i = i + 1) begin
            step(`BSF_FN_SNORM, 4'h0, 4'h0, 1'b1, 1'b0);
            check({z_oe, co, overflow_flag, sgn}, {q != 4'h0, q[3] ^ q[2], q[2] ^ q[1], q[3]});
            check(y, 4'(i + 1));
            q = q << 1;
        end
        step(`BSF_FN_INC, 4'h0, 4'hf, 1'b0, 1'b1);
        load_q(4'hd);
        q = 4'hd;
        p = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            step(`BSF_FN_UMUL, 4'h0, 4'h0, 1'b0, 1'b0);
            s = p + (q[0] ? 5'h0b : 5'h00);
            p = s[4:1];
            q = q >> 1;
            check(y, p);
        end
        finish_test;
    end
endmodule // bsf_slice_tb_top
